// ---- rtl/emc_pkg.sv ----
// Package with constants and types for the error mask and end-signalling block.
package emc_pkg;

  localparam int unsigned ERR_W      = 15;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned STAT_W     = 8;
  localparam int unsigned STAT_ERR_BIT = 5;

  localparam logic [14:0] MASK_RESET = 15'h7fff;
  localparam logic [14:0] ERR_CLEAR  = 15'h0000;

  // Error condition bit positions.
  localparam int unsigned ERR_HW_FAULT    = 0;
  localparam int unsigned ERR_CAL         = 1;
  localparam int unsigned ERR_TRIG_FAST   = 2;
  localparam int unsigned ERR_SYNTAX      = 3;
  localparam int unsigned ERR_REMOTE      = 4;
  localparam int unsigned ERR_UNDEF_PARAM = 5;
  localparam int unsigned ERR_RANGE       = 6;
  localparam int unsigned ERR_MEMORY      = 7;
  localparam int unsigned ERR_OVERLOAD    = 8;
  localparam int unsigned ERR_OUT_OF_CAL  = 9;
  localparam int unsigned ERR_CAL_REQ     = 10;
  localparam int unsigned ERR_SUBSAMPLE   = 11;
  localparam int unsigned ERR_MATH        = 12;
  localparam int unsigned ERR_SUBPROG     = 13;
  localparam int unsigned ERR_SYSTEM      = 14;

  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;

  typedef enum logic [1:0] {
    EMC_END_OFF    = 2'b00,
    EMC_END_ON     = 2'b01,
    EMC_END_ALWAYS = 2'b10
  } emc_end_t;

  typedef enum logic [2:0] {
    EMC_OP_NONE       = 3'b000,
    EMC_OP_MASK_SET   = 3'b001,
    EMC_OP_MASK_DFLT  = 3'b010,
    EMC_OP_MASK_QUERY = 3'b011,
    EMC_OP_ERR_QUERY  = 3'b100,
    EMC_OP_END_SET    = 3'b101,
    EMC_OP_END_DFLT   = 3'b110,
    EMC_OP_END_QUERY  = 3'b111
  } emc_op_t;

  typedef enum logic [1:0] {
    EMC_FMT_PASS  = 2'b00,
    EMC_FMT_COMMA = 2'b01,
    EMC_FMT_CR    = 2'b10,
    EMC_FMT_LF    = 2'b11
  } emc_fmt_t;

endpackage

// ---- rtl/emc_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module emc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ---- rtl/emc_core.sv ----
// Error mask, error register and reading terminator and EOI control.
`timescale 1ns/1ps
// Operation
// R1: Mask has fifteen weighted enable bits.
// R2: Bits 0-7 are the lower error conditions.
// R3: Bits 8-14 are the upper error conditions.
// R4: Mask resets and defaults to all enabled.
// R5: Errors always recorded in error register.
// R6: Mask gates only the status error bit.
// R7: Mask query returns current mask.
// R8: OFF mode never asserts EOI.
// R9: ON mode: EOI at group end or single.
// R10: ALWAYS mode: EOI on every reading end.
// R11: Power-on OFF, parameterless command selects ALWAYS.
// R12: ASCII readings end with CR LF.
// R13: Non-ASCII readings get no terminator.
// R14: Recalled ASCII group: commas, one final CR LF.
// R15: No commas for direct, implied or binary.
// R16: High-speed ALWAYS acts as ON while measuring.
// R17: End query returns active mode.
// R18: Error query returns and clears register, annunciator.
// R19: Error query clears status error bit.
// R20: Status bit set when new error is enabled; code sets it on any new error while any recorded or new error bit is enabled.
module emc_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [14:0] cmd_value,
  output logic             resp_valid_reg,
  output logic [14:0]      resp_data_reg,
  // Error events and status
  input  wire logic [14:0] err_event,
  output logic [7:0]       status_reg,
  output logic             srq_reg,
  output logic             err_annun_reg,
  // Reading source
  input  wire logic        rd_valid,
  output logic             rd_ready_reg,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_last_byte,
  input  wire logic        rd_last_reading,
  input  wire logic        rd_multi,
  input  wire logic        rd_ascii,
  input  wire logic        rd_recall,
  input  wire logic        high_speed,
  input  wire logic        readings_active,
  // Bus byte output
  output logic             bus_valid_reg,
  input  wire logic        bus_ready,
  output logic [7:0]       bus_data_reg,
  output logic             bus_eoi_reg
);

  localparam int unsigned FW = emc_pkg::BYTE_W + 1;

  logic                   rst_meta_reg;
  logic                   rst_n;
  logic [14:0]            mask_reg;
  logic [14:0]            err_reg;
  logic [14:0]            err_next;
  emc_pkg::emc_end_t      end_mode_reg;
  emc_pkg::emc_end_t      end_active;
  emc_pkg::emc_fmt_t      fmt_reg;
  emc_pkg::emc_fmt_t      fmt_next;
  logic                   grp_eoi_reg;
  logic                   is_cmd;
  logic                   err_query;
  logic                   new_err;
  logic                   enabled_hit;
  logic                   rd_take;
  logic                   want_eoi;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic [FW-1:0]          fifo_in_data;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [FW-1:0]          fifo_out_data;

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  assign is_cmd    = cmd_valid;
  assign err_query = is_cmd && (cmd_op == emc_pkg::EMC_OP_ERR_QUERY);

  // Error enable mask.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mask_reg <= emc_pkg::MASK_RESET; // R4
    else if (is_cmd && (cmd_op == emc_pkg::EMC_OP_MASK_SET))
      mask_reg <= cmd_value; // R1
    else if (is_cmd && (cmd_op == emc_pkg::EMC_OP_MASK_DFLT))
      mask_reg <= emc_pkg::MASK_RESET; // R4
  end

  // Each condition bit is recorded regardless of the mask; a new event
  // wins over a clear from the error query in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < emc_pkg::ERR_W; gi++)
    begin : g_err
      assign err_next[gi] = err_event[gi] || (err_reg[gi] && !err_query); // R2 R3 R5 R18
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      err_reg <= emc_pkg::ERR_CLEAR;
    else
      err_reg <= err_next; // R5
  end

  assign new_err     = (err_event != emc_pkg::ERR_CLEAR);
  assign enabled_hit = (((err_reg | err_event) & mask_reg) != emc_pkg::ERR_CLEAR);

  // Status error bit and the service request it raises.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= '0;
      srq_reg    <= 1'b0;
    end
    else if (new_err && enabled_hit)
    begin
      status_reg[emc_pkg::STAT_ERR_BIT] <= 1'b1; // R6 R20
      srq_reg                           <= 1'b1; // R6
    end
    else if (err_query)
    begin
      status_reg[emc_pkg::STAT_ERR_BIT] <= 1'b0; // R19
      srq_reg                           <= 1'b0; // R19
    end
  end

  // Error annunciator follows recorded errors until read out.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      err_annun_reg <= 1'b0;
    else if (new_err)
      err_annun_reg <= 1'b1;
    else if (err_query)
      err_annun_reg <= 1'b0; // R18
  end

  // End-signalling mode.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      end_mode_reg <= emc_pkg::EMC_END_OFF; // R11
    else if (is_cmd && (cmd_op == emc_pkg::EMC_OP_END_SET))
      case (cmd_value[1:0])
        2'b00:   end_mode_reg <= emc_pkg::EMC_END_OFF;
        2'b01:   end_mode_reg <= emc_pkg::EMC_END_ON;
        2'b10:   end_mode_reg <= emc_pkg::EMC_END_ALWAYS;
        default: end_mode_reg <= end_mode_reg;
      endcase
    else if (is_cmd && (cmd_op == emc_pkg::EMC_OP_END_DFLT))
      end_mode_reg <= emc_pkg::EMC_END_ALWAYS; // R11
  end

  // ALWAYS drops to ON while high-speed readings are in progress.
  always_comb
  begin
    if ((end_mode_reg == emc_pkg::EMC_END_ALWAYS) && high_speed && readings_active)
      end_active = emc_pkg::EMC_END_ON; // R16
    else
      end_active = end_mode_reg;
  end

  // Query answers, one cycle after the command.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= '0;
    end
    else
    begin
      resp_valid_reg <= 1'b0;
      if (is_cmd)
      begin
        case (cmd_op)
          emc_pkg::EMC_OP_MASK_QUERY:
          begin
            resp_valid_reg <= 1'b1;
            resp_data_reg  <= mask_reg; // R7
          end
          emc_pkg::EMC_OP_ERR_QUERY:
          begin
            resp_valid_reg <= 1'b1;
            resp_data_reg  <= err_reg; // R18
          end
          emc_pkg::EMC_OP_END_QUERY:
          begin
            resp_valid_reg <= 1'b1;
            resp_data_reg  <= {13'h0000, end_active}; // R17
          end
          default: resp_valid_reg <= 1'b0;
        endcase
      end
    end
  end

  // EOI decision for the reading whose last byte is being taken.
  always_comb
  begin
    case (end_active)
      emc_pkg::EMC_END_OFF:    want_eoi = 1'b0; // R8
      emc_pkg::EMC_END_ON:     want_eoi = !rd_multi || rd_last_reading; // R9
      emc_pkg::EMC_END_ALWAYS: want_eoi = 1'b1; // R10
      default:                 want_eoi = 1'b0;
    endcase
  end

  assign rd_take = rd_valid && rd_ready_reg && fifo_in_ready;

  // Terminator and separator insertion.
  always_comb
  begin
    fmt_next = fmt_reg;
    case (fmt_reg)
      emc_pkg::EMC_FMT_PASS:
        if (rd_take && rd_last_byte && rd_ascii)
        begin
          if (rd_recall && rd_multi && !rd_last_reading)
            fmt_next = emc_pkg::EMC_FMT_COMMA; // R14
          else
            fmt_next = emc_pkg::EMC_FMT_CR; // R12 R15
        end
      emc_pkg::EMC_FMT_COMMA:
        if (fifo_in_ready)
          fmt_next = emc_pkg::EMC_FMT_PASS;
      emc_pkg::EMC_FMT_CR:
        if (fifo_in_ready)
          fmt_next = emc_pkg::EMC_FMT_LF; // R12
      emc_pkg::EMC_FMT_LF:
        if (fifo_in_ready)
          fmt_next = emc_pkg::EMC_FMT_PASS;
      default: fmt_next = emc_pkg::EMC_FMT_PASS;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      fmt_reg <= emc_pkg::EMC_FMT_PASS;
    else
      fmt_reg <= fmt_next;
  end

  // EOI choice is held for the inserted bytes of the same reading.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      grp_eoi_reg <= 1'b0;
    else if (rd_take && rd_last_byte)
      grp_eoi_reg <= want_eoi;
  end

  // Source is stalled only while terminators or commas are inserted, not when the FIFO is full.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ready_reg <= 1'b0;
    end
    else
    begin
      rd_ready_reg <= (fmt_next == emc_pkg::EMC_FMT_PASS);
    end
  end

  always_comb
  begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = '0;
    case (fmt_reg)
      emc_pkg::EMC_FMT_PASS:
      begin
        fifo_in_valid = rd_valid && rd_ready_reg;
        // Binary readings end on their own last byte, no terminator.
        fifo_in_data  = {rd_last_byte && !rd_ascii && want_eoi, rd_data}; // R13
      end
      emc_pkg::EMC_FMT_COMMA:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {grp_eoi_reg, emc_pkg::CHAR_COMMA}; // R14
      end
      emc_pkg::EMC_FMT_CR:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {1'b0, emc_pkg::CHAR_CR}; // R12
      end
      emc_pkg::EMC_FMT_LF:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {grp_eoi_reg, emc_pkg::CHAR_LF}; // R9 R10
      end
      default:
      begin
        fifo_in_valid = 1'b0;
      end
    endcase
  end

  emc_fifo #(
    .WIDTH (FW),
    .DEPTH (emc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !bus_valid_reg || bus_ready;

  // Registered bus byte stage.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_valid_reg <= 1'b0;
      bus_data_reg  <= '0;
      bus_eoi_reg   <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      bus_valid_reg <= fifo_out_valid;
      bus_data_reg  <= fifo_out_data[emc_pkg::BYTE_W-1:0];
      bus_eoi_reg   <= fifo_out_valid && fifo_out_data[emc_pkg::BYTE_W]; // R8
    end
  end

endmodule

// ---- tb/emc_core_sva.sv ----
// Assertion checker for the error mask and end-signalling core.
`timescale 1ns/1ps
module emc_core_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Command port
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic [14:0] cmd_value,
  input wire logic        resp_valid_reg,
  input wire logic [14:0] resp_data_reg,
  // Errors and status
  input wire logic [14:0] err_event,
  input wire logic [7:0]  status_reg,
  input wire logic        srq_reg,
  input wire logic        err_annun_reg,
  // Mode inputs and bus side
  input wire logic        high_speed,
  input wire logic        readings_active,
  input wire logic        bus_valid_reg,
  input wire logic        bus_ready,
  input wire logic [7:0]  bus_data_reg,
  input wire logic        bus_eoi_reg
);
  logic [14:0] mask_h;
  logic [1:0]  mode_h;
  logic [1:0]  act_h;

  // Shadow copies of the mask and end mode, followed from the commands.
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      mask_h <= 15'h7fff;
    else if (cmd_valid && cmd_op == 3'h1)
      mask_h <= cmd_value;
    else if (cmd_valid && cmd_op == 3'h2)
      mask_h <= 15'h7fff;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      mode_h <= 2'h0;
    else if (cmd_valid && cmd_op == 3'h5 && cmd_value[1:0] != 2'h3)
      mode_h <= cmd_value[1:0];
    else if (cmd_valid && cmd_op == 3'h6)
      mode_h <= 2'h2;

  assign act_h = (mode_h == 2'h2 && high_speed && readings_active) ? 2'h1 : mode_h;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence err_query_s;
    cmd_valid && cmd_op == 3'h4 && err_event == 15'h0000;
  endsequence
  sequence err_cleared_s;
    resp_valid_reg && !status_reg[5] && !err_annun_reg;
  endsequence

  err_clear_a: assert property (err_query_s |=> err_cleared_s)
    else $error("error query left status or annunciator set");
  query_answer_a: assert property (cmd_valid && cmd_op inside {3'h3, 3'h4, 3'h7} |=> resp_valid_reg)
    else $error("query gave no answer");
  set_silent_a: assert property (cmd_valid && cmd_op inside {3'h1, 3'h2, 3'h5, 3'h6} |=> !resp_valid_reg)
    else $error("setting command gave an answer");
  mask_query_a: assert property (cmd_valid && cmd_op == 3'h3 |=> resp_data_reg == $past(mask_h))
    else $error("mask query value wrong");
  end_query_a: assert property (cmd_valid && cmd_op == 3'h7 |=> resp_data_reg == {13'h0000, $past(act_h)})
    else $error("end mode query value wrong");
  status_set_a: assert property ((err_event & mask_h) != 15'h0000 |=> status_reg[5] && srq_reg)
    else $error("enabled error did not set status");
  status_form_a: assert property (status_reg == {2'b00, srq_reg, 5'b00000})
    else $error("status byte form wrong");
  eoi_off_a: assert property (bus_valid_reg && bus_eoi_reg |-> mode_h != 2'h0)
    else $error("end marker sent in off mode");
  bus_hold_a: assert property (bus_valid_reg && !bus_ready |=> bus_valid_reg && $stable(bus_data_reg) && $stable(bus_eoi_reg))
    else $error("bus byte changed before acceptance");
endmodule

// ---- tb/emc_host_model.sv ----
// Bus controller model that takes bytes from the core, optionally stalling every other cycle.
`timescale 1ns/1ps
module emc_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Byte link from the core
  input  wire logic       bus_valid_reg,
  output logic            bus_ready,
  input  wire logic [7:0] bus_data_reg,
  input  wire logic       bus_eoi_reg,
  // Stall control
  input  wire logic       slow
);
  logic [8:0] got[$];

  // The end marker is kept with each byte so the bench can see where messages end.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bus_ready <= 1'b0;
    else
    begin
      if (bus_valid_reg && bus_ready)
        got.push_back({bus_eoi_reg, bus_data_reg});
      bus_ready <= slow ? !bus_ready : 1'b1;
    end
  end
endmodule

// ---- tb/emc_core_tb.sv ----
// Self-checking bench for the error mask and end-signalling core.
`timescale 1ns/1ps
module emc_core_tb;
  logic        clk_sys, rstn, cmd_valid, resp_valid_reg, srq_reg, err_annun_reg, slow;
  logic [2:0]  cmd_op;
  logic [14:0] cmd_value, resp_data_reg, err_event;
  logic [7:0]  status_reg, rd_data, bus_data_reg;
  logic        rd_valid, rd_ready_reg, rd_last_byte, rd_last_reading, rd_multi, rd_ascii;
  logic        rd_recall, high_speed, readings_active, bus_valid_reg, bus_ready, bus_eoi_reg;
  int          n_fail, num_checks;
  logic [1:0]  mode;
  logic [8:0]  exp_q[$];

  emc_core u_emc_core (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_value(cmd_value), .resp_valid_reg(resp_valid_reg), .resp_data_reg(resp_data_reg),
    .err_event(err_event), .status_reg(status_reg), .srq_reg(srq_reg),
    .err_annun_reg(err_annun_reg), .rd_valid(rd_valid), .rd_ready_reg(rd_ready_reg),
    .rd_data(rd_data), .rd_last_byte(rd_last_byte), .rd_last_reading(rd_last_reading),
    .rd_multi(rd_multi), .rd_ascii(rd_ascii), .rd_recall(rd_recall), .high_speed(high_speed),
    .readings_active(readings_active), .bus_valid_reg(bus_valid_reg), .bus_ready(bus_ready),
    .bus_data_reg(bus_data_reg), .bus_eoi_reg(bus_eoi_reg));
  emc_host_model u_emc_host_model (.clk_sys(clk_sys), .rstn(rstn), .bus_valid_reg(bus_valid_reg),
    .bus_ready(bus_ready), .bus_data_reg(bus_data_reg), .bus_eoi_reg(bus_eoi_reg), .slow(slow));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmd(input logic [2:0] op, input logic [14:0] val);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_value <= val;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic qry(input logic [2:0] op, input logic [14:0] exp, input string name);
    cmd(op, 15'h0000);
    chk("answer strobe", 15'h0001, {14'h0000, resp_valid_reg});
    chk(name, exp, resp_data_reg);
  endtask

  task automatic raise(input logic [14:0] bits);
    @(posedge clk_sys);
    err_event <= bits;
    @(posedge clk_sys);
    err_event <= 15'h0000;
    #1;
  endtask

  task automatic put(input logic [7:0] d, input logic lb);
    int k = 0;
    @(posedge clk_sys);
    rd_valid     <= 1'b1;
    rd_data      <= d;
    rd_last_byte <= lb;
    @(posedge clk_sys);
    while (rd_ready_reg !== 1'b1 && k < 50)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 50)
      n_fail++;
    rd_valid <= 1'b0;
  endtask

  // Sends one reading and queues the bytes the bus should carry for it in the current mode.
  task automatic reading(input logic [7:0] b, input int n, input logic lr, mu, as, rc);
    logic e;
    e = (mode == 2'h2) || (mode == 2'h1 && (!mu || lr));
    @(posedge clk_sys);
    rd_last_reading <= lr;
    rd_multi        <= mu;
    rd_ascii        <= as;
    rd_recall       <= rc;
    for (int i = 0; i < n; i++)
    begin
      put(b + 8'(i), i == n - 1);
      exp_q.push_back({!as && e && i == n - 1, b + 8'(i)});
    end
    if (as && rc && mu && !lr)
      exp_q.push_back({mode == 2'h2, emc_pkg::CHAR_COMMA});
    else if (as)
    begin
      exp_q.push_back({1'b0, emc_pkg::CHAR_CR});
      exp_q.push_back({e, emc_pkg::CHAR_LF});
    end
  endtask

  task automatic drain;
    int k = 0;
    while (u_emc_host_model.got.size() < exp_q.size() && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    chk("byte count", 15'(exp_q.size()), 15'(u_emc_host_model.got.size()));
    foreach (exp_q[i])
      if (i < u_emc_host_model.got.size())
        chk("bus byte", 15'(exp_q[i]), 15'(u_emc_host_model.got[i]));
    exp_q.delete();
    u_emc_host_model.got.delete();
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  initial
  begin
    {rstn, cmd_valid, cmd_op, cmd_value, err_event, slow, high_speed, readings_active} = '0;
    {rd_valid, rd_data, rd_last_byte, rd_last_reading, rd_multi, rd_ascii, rd_recall} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    qry(3'h3, 15'h7fff, "mask");
    qry(3'h7, 15'h0000, "end mode");
    cmd(3'h1, 15'h00f8);
    qry(3'h3, 15'h00f8, "mask");
    raise(15'h0004);
    chk("status", 15'h0000, {7'h00, status_reg});
    chk("annunciator", 15'h0001, {14'h0000, err_annun_reg});
    raise(15'h0008);
    chk("status", 15'h0020, {7'h00, status_reg});
    qry(3'h4, 15'h000c, "error register");
    chk("status", 15'h0000, {7'h00, status_reg});
    chk("annunciator", 15'h0000, {14'h0000, err_annun_reg});
    for (int i = 0; i < 15; i++)
    begin
      cmd(3'h1, 15'h0001 << i);
      raise(15'h0001 << i);
      chk("service request", 15'h0001, {14'h0000, srq_reg});
      qry(3'h4, 15'h0001 << i, "error register");
    end
    cmd(3'h2, 15'h0000);
    qry(3'h3, 15'h7fff, "mask");
    for (int c = 0; c < 3; c++)
    begin
      cmd(3'h5, 15'(c));
      qry(3'h7, 15'(c), "end mode");
    end
    cmd(3'h5, 15'h0003);
    qry(3'h7, 15'h0002, "end mode");
    cmd(3'h5, 15'h0000);
    cmd(3'h6, 15'h0000);
    qry(3'h7, 15'h0002, "end mode");
    @(posedge clk_sys);
    high_speed      <= 1'b1;
    readings_active <= 1'b1;
    qry(3'h7, 15'h0001, "end mode");
    @(posedge clk_sys);
    readings_active <= 1'b0;
    qry(3'h7, 15'h0002, "end mode");
    mode = 2'h2;
    reading(8'h35, 1, 1'b1, 1'b0, 1'b1, 1'b0);
    reading(8'h31, 1, 1'b0, 1'b1, 1'b1, 1'b0);
    reading(8'h32, 1, 1'b1, 1'b1, 1'b1, 1'b0);
    drain();
    cmd(3'h5, 15'h0000);
    mode = 2'h0;
    reading(8'h35, 1, 1'b1, 1'b0, 1'b1, 1'b0);
    drain();
    cmd(3'h5, 15'h0001);
    mode = 2'h1;
    @(posedge clk_sys);
    slow <= 1'b1;
    reading(8'h31, 1, 1'b0, 1'b1, 1'b1, 1'b1);
    reading(8'h32, 1, 1'b1, 1'b1, 1'b1, 1'b1);
    drain();
    reading(8'h40, 2, 1'b0, 1'b1, 1'b0, 1'b0);
    reading(8'h50, 2, 1'b1, 1'b1, 1'b0, 1'b0);
    reading(8'h36, 1, 1'b1, 1'b0, 1'b1, 1'b0);
    drain();
    final_report();
  end
endmodule

bind emc_core emc_core_sva u_emc_core_sva (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_value(cmd_value), .resp_valid_reg(resp_valid_reg),
  .resp_data_reg(resp_data_reg), .err_event(err_event), .status_reg(status_reg),
  .srq_reg(srq_reg), .err_annun_reg(err_annun_reg), .high_speed(high_speed),
  .readings_active(readings_active), .bus_valid_reg(bus_valid_reg), .bus_ready(bus_ready),
  .bus_data_reg(bus_data_reg), .bus_eoi_reg(bus_eoi_reg));
